// ==== core/ohc_params.svh ====
// constants for the overhead status codec on the remote (host) side
// assumes inclusion by bare name from every design file that needs it
`ifndef OHC_PARAMS_SVH
`define OHC_PARAMS_SVH
`define OHC_BEI_MAX        4'h8
`define OHC_BIAE_CODE      4'hb
`define OHC_TTI_LEN        7'h40
`define OHC_TTI_OPER_START 6'h20
`define OHC_MF_LAST        8'hff
`define OHC_FTFL_LEN       8'h80
`define OHC_FTFL_OPER_LEN  8'h76
`define OHC_FTFL_CC_LEN    4'h3
`define OHC_FTFL_NSC_MAX   4'h6
`define OHC_FIF_NONE       8'h00
`define OHC_FIF_SF         8'h01
`define OHC_FIF_SD         8'h02
`define OHC_STAT_NO_SRC    3'h0
`define OHC_STAT_NO_IAE    3'h1
`define OHC_STAT_IAE       3'h2
`define OHC_STAT_LCK       3'h5
`define OHC_STAT_OCI       3'h6
`define OHC_STAT_AIS       3'h7
`define OHC_PM_STAT_NORMAL 3'h1
`define OHC_FIELDS         3'h7
`endif

// ==== core/ohc_pkg.sv ====
// types shared by the overhead status codec files
// assumes ohc_params.svh is on the include path
package ohc_pkg;
  typedef enum logic [2:0] {
    STAT_NO_SRC = 3'h0,
    STAT_NO_IAE = 3'h1,
    STAT_IAE    = 3'h2,
    STAT_RES3   = 3'h3,
    STAT_RES4   = 3'h4,
    STAT_LCK    = 3'h5,
    STAT_OCI    = 3'h6,
    STAT_AIS    = 3'h7
  } stat_type;

  typedef enum logic [7:0] {
    FIF_NONE = 8'h00,
    FIF_SF   = 8'h01,
    FIF_SD   = 8'h02
  } fif_type;

  // decoded view of one status byte
  typedef struct packed {
    logic [3:0] bip_errors;
    logic       biae;
    logic       bdi;
    logic       iae;
    logic [2:0] stat;
  } status_type;

  // one overhead monitoring triplet as seen on the wire
  typedef struct packed {
    logic [7:0] tti;
    logic [7:0] bip8;
    logic [7:0] status;
  } triplet_type;

  typedef enum logic [1:0] {
    FT_FIF  = 2'b00,
    FT_OPID = 2'b01,
    FT_OPER = 2'b11
  } ftfl_state_type;
endpackage

// ==== core/ohc_status_byte.sv ====
// status byte encoder/decoder for one SM, TCM or PM field
// assumes combinational use inside the codec; bit 1 of the byte is the msb
`timescale 1ns/1ps
`include "ohc_params.svh"
module ohc_status_byte
  import ohc_pkg::*;
#(
  parameter logic IS_SM  = 1'b0,
  parameter logic IS_PM  = 1'b0
) (
  input  wire logic [3:0] bei_i,
  input  wire logic       biae_i,
  input  wire logic       sf_i,
  input  wire logic       iae_i,
  input  wire logic [2:0] stat_i,
  output logic      [7:0] byte_o,
  input  wire logic [7:0] byte_i,
  output status_type      dec_o
);
  logic [3:0] bei_c;
  logic [3:0] rx_code;
  always_comb begin
    // counts above eight cannot be sent; saturate rather than alias
    bei_c = (bei_i > `OHC_BEI_MAX) ? `OHC_BEI_MAX : bei_i;
    byte_o[7:4] = (biae_i && !IS_PM) ? `OHC_BIAE_CODE : bei_c;
    byte_o[3] = sf_i;
    if (IS_SM) begin
      byte_o[2] = iae_i;
      byte_o[1:0] = 2'b00;
    end else begin
      byte_o[2:0] = stat_i;
    end
    rx_code = byte_i[7:4];
    dec_o.biae = !IS_PM && (rx_code == `OHC_BIAE_CODE);
    dec_o.bip_errors = (rx_code > `OHC_BEI_MAX) ? 4'h0 : rx_code;
    dec_o.bdi = byte_i[3];
    dec_o.iae = IS_SM ? byte_i[2] : 1'b0;
    dec_o.stat = IS_SM ? 3'h0 : byte_i[2:0];
  end
endmodule

// ==== core/otn_overhead_status_codec.sv ====
// remote network element side of the overhead monitoring codec
// assumes one 50 MHz clock, frame_start_i once per OTU frame, inputs on this clock
//==============================================================
// Overview of operation
// - BEI code 0..8 gives error count; codes 9..15 read as zero.
// - code 1011 alone means BIAE and counts no errors.
// - each TCM is TTI, BIP-8, status: BEI/BIAE, BDI, STAT.
// - TCM STAT codes: none, no IAE, IAE, reserved, LCK, OCI, AIS.
// - TTI is 64 bytes, one per frame, multiframe aligned.
// - TTI holds SAPI, DAPI and a 32-byte operator part.
// - FTFL is forward and backward 128-byte fields.
// - fault indication 00 none, 01 SF, 02 SD, others reserved.
// - operator identifier starts with a three-character country code.
// - then a national segment code of one to six characters.
// - PM status: BEI only, BDI, STAT.
// - byte order in each field: TTI, BIP-8, status.
`timescale 1ns/1ps
`include "ohc_params.svh"
module otn_overhead_status_codec
  import ohc_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              frame_start_i,
  // local transmit settings, index 0 = SM, 1..6 = TCM1..6, 7 = PM; TCM STAT index 0..5 = TCM1..6, PM BEI separate
  input  wire logic [6:0][3:0]   tx_bei_i,
  input  wire logic [6:0]        tx_biae_i,
  input  wire logic [7:0]        tx_sf_i,
  input  wire logic              tx_iae_i,
  input  wire logic [5:0][2:0]   tx_tcm_stat_i,
  input  wire logic [3:0]        tx_pm_bei_i,
  input  wire logic [7:0][7:0]   tx_bip8_i,
  input  wire logic [7:0]        tti_byte_i,
  output logic      [5:0]        tti_addr_o,
  input  wire logic [2:0][7:0]   tx_gcc_i,
  input  wire logic              tx_ftfl_fwd_i,
  input  wire logic [7:0]        tx_fif_i,
  input  wire logic [3:0]        tx_nsc_len_i,
  input  wire logic [7:0]        ftfl_src_byte_i,
  // transmit overhead toward the device
  output triplet_type [7:0]      ovh_tx_o,
  output logic      [2:0][7:0]   gcc_tx_o,
  output logic      [7:0]        ftfl_tx_o,
  output logic      [7:0]        ftfl_idx_o,
  output logic      [7:0]        mfas_o,
  // receive overhead from the device
  input  wire triplet_type [7:0] ovh_rx_i,
  input  wire logic [2:0][7:0]   gcc_rx_i,
  output status_type  [7:0]      rx_status_o,
  output logic      [7:0]        rx_tti_byte_o,
  output logic      [5:0]        rx_tti_addr_o,
  output logic      [2:0][7:0]   gcc_rx_o,
  output logic                   rx_valid_o
);
  //==============================================================
  // multiframe counter and ttI position
  logic [7:0] mf_q;
  logic [7:0] mf_d;
  always_comb begin
    mf_d = mf_q;
    if (frame_start_i) begin
      mf_d = (mf_q == `OHC_MF_LAST) ? 8'h00 : mf_q + 8'h01;
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mf_q <= 8'h00;
    end else begin
      mf_q <= mf_d;
    end
  end
  // the tti byte index is the low six bits of the multiframe count, so the
  // 64-byte message repeats four times per multiframe
  assign tti_addr_o = mf_q[5:0];

  //==============================================================
  // status byte codecs for SM, TCM1..6 and PM
  logic [7:0][7:0] st_tx;
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_st
      ohc_status_byte #(
        .IS_SM (g == 0),
        .IS_PM (g == 7)
      ) u_st (
        .bei_i  ((g == 7) ? tx_pm_bei_i : tx_bei_i[(g == 7) ? 0 : g]),
        .biae_i ((g == 7) ? 1'b0 : tx_biae_i[(g == 7) ? 0 : g]),
        .sf_i   (tx_sf_i[g]),
        .iae_i  (tx_iae_i),
        .stat_i ((g == 0) ? 3'h0 :
                 (g == 7) ? `OHC_PM_STAT_NORMAL : tx_tcm_stat_i[(g == 0) ? 0 : g - 1]),
        .byte_o (st_tx[g]),
        .byte_i (ovh_rx_i[g].status),
        .dec_o  (rx_status_o[g])
      );
    end
  endgenerate

  //==============================================================
  // FTFL message sequencer: FIF, country code, nsc, pad, operator area
  ftfl_state_type ft_q;
  ftfl_state_type ft_d;
  logic [7:0] fidx_q;
  logic [7:0] fidx_d;
  logic [7:0] fbyte_d;
  logic [7:0] fbyte_q;
  logic [7:0] opid_idx;
  always_comb begin
    ft_d = ft_q;
    fidx_d = fidx_q;
    fbyte_d = 8'h00;
    opid_idx = fidx_q - 8'h01;
    if (frame_start_i) begin
      fidx_d = (fidx_q == `OHC_FTFL_LEN - 8'h01) ? 8'h00 : fidx_q + 8'h01;
    end
    unique case (ft_q)
      FT_FIF: begin
        // reserved indications are never sent; fall back to no fault
        fbyte_d = (tx_fif_i > `OHC_FIF_SD) ? `OHC_FIF_NONE : tx_fif_i;
        if (frame_start_i) ft_d = FT_OPID;
      end
      FT_OPID: begin
        if (opid_idx < {4'h0, `OHC_FTFL_CC_LEN}) begin
          fbyte_d = ftfl_src_byte_i;
        end else if (opid_idx < {4'h0, `OHC_FTFL_CC_LEN} + {4'h0, tx_nsc_len_i}
                     && tx_nsc_len_i <= `OHC_FTFL_NSC_MAX) begin
          fbyte_d = ftfl_src_byte_i;
        end
        if (frame_start_i && fidx_q == `OHC_FTFL_LEN - `OHC_FTFL_OPER_LEN - 8'h01) begin
          ft_d = FT_OPER;
        end
      end
      FT_OPER: begin
        fbyte_d = ftfl_src_byte_i;
        if (frame_start_i && fidx_q == `OHC_FTFL_LEN - 8'h01) ft_d = FT_FIF;
      end
      default: ft_d = FT_FIF;
    endcase
  end
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ft_q <= FT_FIF;
      fidx_q <= 8'h00;
      fbyte_q <= 8'h00;
    end else begin
      ft_q <= ft_d;
      fidx_q <= fidx_d;
      fbyte_q <= fbyte_d;
    end
  end
  assign ftfl_idx_o = tx_ftfl_fwd_i ? fidx_q : fidx_q | `OHC_FTFL_LEN;
  assign ftfl_tx_o = fbyte_q;

  //==============================================================
  // output registers, loaded at frame start
  triplet_type [7:0] tx_q;
  triplet_type [7:0] tx_d;
  logic [2:0][7:0] gtx_q;
  logic [2:0][7:0] gtx_d;
  logic [2:0][7:0] grx_q;
  logic [2:0][7:0] grx_d;
  logic [7:0] rtti_q;
  logic [7:0] rtti_d;
  logic [5:0] raddr_q;
  logic [5:0] raddr_d;
  logic rval_q;
  logic rval_d;
  always_comb begin
    tx_d = tx_q;
    gtx_d = gtx_q;
    grx_d = grx_q;
    rtti_d = rtti_q;
    raddr_d = raddr_q;
    rval_d = 1'b0;
    if (frame_start_i) begin
      for (int i = 0; i < 8; i++) begin
        tx_d[i].tti = tti_byte_i;
        tx_d[i].bip8 = tx_bip8_i[i];
        tx_d[i].status = st_tx[i];
      end
      gtx_d = tx_gcc_i;
      grx_d = gcc_rx_i;
      rtti_d = ovh_rx_i[0].tti;
      raddr_d = mf_q[5:0];
      rval_d = 1'b1;
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_q <= '0;
      gtx_q <= '0;
      grx_q <= '0;
      rtti_q <= 8'h00;
      raddr_q <= 6'h00;
      rval_q <= 1'b0;
    end else begin
      tx_q <= tx_d;
      gtx_q <= gtx_d;
      grx_q <= grx_d;
      rtti_q <= rtti_d;
      raddr_q <= raddr_d;
      rval_q <= rval_d;
    end
  end
  assign ovh_tx_o = tx_q;
  assign gcc_tx_o = gtx_q;
  assign gcc_rx_o = grx_q;
  assign rx_tti_byte_o = rtti_q;
  assign rx_tti_addr_o = raddr_q;
  assign rx_valid_o = rval_q;
  assign mfas_o = mf_q;
endmodule

// ==== tb/ohc_checker_assertions.sv ====
// port checker for the overhead status codec
// assumes bind onto otn_overhead_status_codec, ports watched by name
`timescale 1ns/1ps
module ohc_checker
  import ohc_pkg::*;
(
  input wire logic              core_clk_i,
  input wire logic              rst_n_i,
  input wire logic              frame_start_i,
  input wire logic              tx_iae_i,
  input wire logic [7:0]        tx_sf_i,
  input wire logic [2:0][7:0]   gcc_rx_i,
  input wire triplet_type [7:0] ovh_tx_o,
  input wire triplet_type [7:0] ovh_rx_i,
  input wire status_type [7:0]  rx_status_o,
  input wire logic [2:0][7:0]   gcc_rx_o,
  input wire logic [7:0]        mfas_o,
  input wire logic              rx_valid_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  //==========================================
  // frame timing
  mfas_step_a: assert property (frame_start_i |=> mfas_o == $past(mfas_o) + 8'h01)
    else $error("frame count did not step");
  mfas_hold_a: assert property (!frame_start_i |=> $stable(mfas_o))
    else $error("frame count moved without a frame");
  valid_pulse_a: assert property (rx_valid_o == $past(frame_start_i))
    else $error("receive valid out of step");
  //==========================================
  // status bytes and gcc receive copy
  sm_iae_a: assert property (frame_start_i |=> ovh_tx_o[0].status[2] == $past(tx_iae_i))
    else $error("sm iae bit wrong");
  sm_res_a: assert property (ovh_tx_o[0].status[1:0] == 2'b00)
    else $error("sm reserved bits set");
  pm_bdi_a: assert property (frame_start_i |=> ovh_tx_o[7].status[3] == $past(tx_sf_i[7]))
    else $error("pm bdi bit wrong");
  biae_dec_a: assert property (rx_status_o[1].biae == (ovh_rx_i[1].status[7:4] == 4'hb))
    else $error("biae decode wrong");
  bei_dec_a: assert property (rx_status_o[0].bip_errors == ((ovh_rx_i[0].status[7:4] > 4'h8) ?
    4'h0 : ovh_rx_i[0].status[7:4]))
    else $error("bei decode wrong");
  gcc_rx_a: assert property (frame_start_i |=> gcc_rx_o == $past(gcc_rx_i))
    else $error("gcc receive copy wrong");
endmodule

bind otn_overhead_status_codec ohc_checker chk (.core_clk_i, .rst_n_i, .frame_start_i,
  .tx_iae_i, .tx_sf_i, .gcc_rx_i, .ovh_tx_o, .ovh_rx_i, .rx_status_o, .gcc_rx_o, .mfas_o,
  .rx_valid_o);

// ==== tb/ohc_line_model.sv ====
// far network element: sends overhead triplets and gcc bytes each frame
// assumes frame_start_i shared with the codec
`timescale 1ns/1ps
module ohc_line_model
  import ohc_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        frame_start_i,
  input  wire logic [3:0]  bei_code_i,
  output triplet_type [7:0] ovh_rx_o,
  output logic [2:0][7:0]  gcc_rx_o
);
  logic [7:0] cnt_q;
  //==========================================
  // frame counter drives changing tti, parity and gcc contents
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 8'h00;
    end else if (frame_start_i) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  always_comb begin
    for (int f = 0; f < 8; f++) begin
      ovh_rx_o[f].tti = cnt_q;
      ovh_rx_o[f].bip8 = ~cnt_q;
      ovh_rx_o[f].status = {bei_code_i, 1'b1, 3'h1};
    end
    gcc_rx_o = {3{cnt_q ^ 8'h5a}};
  end
endmodule

// ==== tb/otn_overhead_status_codec_tb_top.sv ====
// bench for the overhead status codec facing a line model
// assumes ohc_pkg compiled first and the checker bound to the codec
`timescale 1ns/1ps
module otn_overhead_status_codec_tb_top;
  import ohc_pkg::*;
  logic              core_clk_i, rst_n_i, frame_start_i, tx_iae_i, rx_valid_o;
  logic [6:0][3:0]   tx_bei_i;
  logic [6:0]        tx_biae_i;
  logic [7:0]        tx_sf_i, mfas_o;
  logic [3:0]        tx_pm_bei_i, bei_code;
  logic [5:0][2:0]   tx_tcm_stat_i;
  logic [7:0][7:0]   tx_bip8_i;
  logic [2:0][7:0]   tx_gcc_i, gcc_tx_o, gcc_rx_i, gcc_rx_o;
  triplet_type [7:0] ovh_tx_o, ovh_rx_i;
  status_type [7:0]  rx_status_o;
  logic [7:0]        fif, src_byte, ftfl_tx, ftfl_idx, rx_tti_byte, tti_byte;
  logic [5:0]        tti_addr, rx_tti_addr;
  logic [3:0]        nsc_len;
  int                n_fail = 0;
  int                check_count = 0;
  int                cycles = 0;

  otn_overhead_status_codec dut (.core_clk_i, .rst_n_i, .frame_start_i, .tx_bei_i, .tx_biae_i,
    .tx_sf_i, .tx_iae_i, .tx_tcm_stat_i, .tx_pm_bei_i, .tx_bip8_i, .tti_byte_i(tti_byte),
    .tti_addr_o(tti_addr), .tx_gcc_i, .tx_ftfl_fwd_i(1'b0), .tx_fif_i(fif),
    .tx_nsc_len_i(nsc_len), .ftfl_src_byte_i(src_byte), .ovh_tx_o, .gcc_tx_o,
    .ftfl_tx_o(ftfl_tx), .ftfl_idx_o(ftfl_idx), .mfas_o, .ovh_rx_i, .gcc_rx_i, .rx_status_o,
    .rx_tti_byte_o(rx_tti_byte), .rx_tti_addr_o(rx_tti_addr), .gcc_rx_o, .rx_valid_o);
  // local trace store: each byte carries its own index so misalignment shows
  assign tti_byte = {2'b01, tti_addr};
  ohc_line_model line (.core_clk_i, .rst_n_i, .frame_start_i, .bei_code_i(bei_code),
    .ovh_rx_o(ovh_rx_i), .gcc_rx_o(gcc_rx_i));

  //==========================================
  // clock, hang guard and shared tasks
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  // the full run needs about 740 cycles
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail = n_fail + 1;
      conclude();
    end
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic frame();
    frame_start_i <= 1'b1;
    @(posedge core_clk_i);
    frame_start_i <= 1'b0;
    @(negedge core_clk_i);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  //==========================================
  // scenarios
  task automatic t_tx(input logic [3:0] b, input logic [2:0] s0);
    logic [3:0] sat;
    sat = (b > 4'h8) ? 4'h8 : b;
    @(posedge core_clk_i);
    tx_bei_i <= {7{b}};
    for (int i = 0; i < 6; i++) tx_tcm_stat_i[i] <= s0 + 3'(i);
    tx_bip8_i <= {8{b, ~s0, 1'b0}};
    tx_gcc_i <= {3{4'h0, b}};
    frame();
    chk("sm status", {sat, 2'b11, 2'b00}, ovh_tx_o[0].status);
    chk("tcm1 status", {4'hb, 1'b0, s0}, ovh_tx_o[1].status);
    for (int i = 2; i < 7; i++) chk("tcm status", {sat, 1'b0, s0 + 3'(i - 1)}, ovh_tx_o[i].status);
    chk("pm status", {4'h3, 1'b1, 3'h1}, ovh_tx_o[7].status);
    for (int i = 0; i < 8; i++) chk("parity byte", tx_bip8_i[i], ovh_tx_o[i].bip8);
    chk("gcc", {4'h0, b}, gcc_tx_o[2]);
  endtask
  task automatic t_rx();
    logic [7:0] e;
    for (int c = 0; c < 16; c++) begin
      @(posedge core_clk_i);
      bei_code <= 4'(c);
      frame();
      e = (c > 8) ? 8'h00 : 8'(c);
      chk("tcm errors", e, {4'h0, rx_status_o[1].bip_errors});
      chk("tcm biae", {7'h0, c == 11}, {7'h0, rx_status_o[1].biae});
      chk("pm errors", e, {4'h0, rx_status_o[7].bip_errors});
      chk("sm bdi", 8'h01, {7'h0, rx_status_o[0].bdi});
      chk("frame valid", 8'h01, {7'h0, rx_valid_o});
      chk("tti index", {2'b01, 6'(mfas_o - 8'h01)}, ovh_tx_o[0].tti);
      chk("rx tti byte", ovh_rx_i[0].tti - 8'h01, rx_tti_byte);
      chk("rx tti index", {2'b00, 6'(mfas_o - 8'h01)}, {2'b00, rx_tti_addr});
    end
  endtask
  task automatic t_mfas();
    logic [7:0] m;
    m = mfas_o;
    @(posedge core_clk_i);
    frame_start_i <= 1'b1;
    repeat (200) @(posedge core_clk_i);
    frame_start_i <= 1'b0;
    @(negedge core_clk_i);
    chk("frame count", m + 8'hc8, mfas_o);
    repeat (56) begin
      @(posedge core_clk_i);
      frame();
    end
    chk("frame wrap", m, mfas_o);
  endtask
  // walks one full backward message; the byte is registered one edge after the index
  task automatic t_ftfl();
    logic [7:0] e;
    logic [6:0] k;
    for (int n = 0; n < 128; n++) begin
      @(posedge core_clk_i);
      frame();
      @(posedge core_clk_i);
      @(negedge core_clk_i);
      k = ftfl_idx[6:0];
      if (k == 7'h00) e = 8'h00;
      else if (k < 7'h04 + 7'(nsc_len)) e = src_byte;
      else if (k < 7'h0a) e = 8'h00;
      else e = src_byte;
      chk("ftfl byte", e, ftfl_tx);
      chk("ftfl backward", 8'h80, {ftfl_idx[7], 7'h00});
    end
  endtask

  initial begin
    rst_n_i = 1'b0;
    frame_start_i = 1'b0;
    tx_iae_i = 1'b1;
    tx_biae_i = 7'h02;
    tx_sf_i = 8'h81;
    tx_pm_bei_i = 4'h3;
    tx_bei_i = '0;
    tx_tcm_stat_i = '0;
    tx_bip8_i = '0;
    tx_gcc_i = '0;
    bei_code = 4'h0;
    fif = 8'h07;
    nsc_len = 4'h3;
    src_byte = 8'h41;
    repeat (3) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    t_tx(4'hc, 3'h0);
    t_tx(4'h8, 3'h2);
    t_rx();
    t_mfas();
    t_ftfl();
    conclude();
  end
endmodule
